// [design/ncl_loader.sv]
// Nonvolatile configuration store and reload engine
//
// Functional notes
// - Twenty-three byte segment table describes copied ranges
// - Table also holds apply and end opcodes
// - Reset table copies five address ranges (227 bytes), then applies
// - Busy bit reads one during transfer
// - Error bit reads one on bad data
// - Reload bit with select low restores config
// - Reload bit clears itself next cycle
// - Write-enable bit, default zero, guards stores
// - Store bit starts copy, clears when done
// - Apply moves all buffer registers to active
`timescale 1ns/1ps
`default_nettype none
module ncl_loader #(
   parameter int NVM_AW = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access from the serial port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Memory-select pin, low lets a reload read the memory; stores ignore it
   input wire logic nvm_sel_n,
   // Nonvolatile memory
   output logic nvm_req,
   output logic nvm_we,
   output logic [NVM_AW-1:0] nvm_addr,
   output logic [7:0] nvm_wdata,
   input wire logic nvm_ack,
   input wire logic [7:0] nvm_rdata,
   // Buffer registers
   output logic [11:0] cfg_addr,
   input wire logic [7:0] cfg_rdata,
   output logic cfg_wr,
   output logic [7:0] cfg_wdata,
   output logic cfg_apply,
   output logic cfg_soft_rst
);
   import ncl_pkg::*;
   if (NVM_AW < 8 || NVM_AW > 24) begin : g_chk
      $error("ncl_loader: NVM_AW out of range");
   end

   localparam logic [NVM_AW-1:0] NVM_ONE = NVM_AW'(1);

   ncl_state_e st_q, st_d;
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [6:0] cnt_q, cnt_d;
   logic [11:0] cfg_addr_q, cfg_addr_d;
   logic cfg_wr_q, cfg_wr_d;
   logic [7:0] cfg_wdata_q, cfg_wdata_d;
   logic apply_q, apply_d, srst_q, srst_d;
   logic req_q, req_d, we_q, we_d;
   logic [NVM_AW-1:0] naddr_q, naddr_d;
   logic [7:0] nwdata_q, nwdata_d;
   logic [7:0] sum_q, sum_d;
   logic err_q, err_d, load_q, load_d;
   logic wen_q, wen_d, reload_q, reload_d, store_q, store_d;
   logic [7:0] rdata_q, rdata_d;
   logic sel_meta_q, sel_s_q;
   logic busy;
   logic [7:0] tbl_host, tbl_b0, tbl_b1, tbl_b2;

   function automatic logic tbl_hit(input logic [11:0] a);
      tbl_hit = (a >= ADDR_TBL_FIRST) && (a <= ADDR_TBL_LAST);
   endfunction

   function automatic logic [IDX_W-1:0] tbl_idx(input logic [11:0] a);
      logic [11:0] off;
      off = a - ADDR_TBL_FIRST;
      tbl_idx = off[IDX_W-1:0];
   endfunction

   ncl_seg_table #(.DEPTH(TBL_DEPTH)) u_tbl (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(reg_wr && tbl_hit(reg_addr) && !busy),
      .wr_idx(tbl_idx(reg_addr)),
      .wr_data(reg_wdata),
      .rd_idx(tbl_idx(reg_addr)),
      .rd_data(tbl_host),
      .ld_idx(idx_q),
      .ld_b0(tbl_b0),
      .ld_b1(tbl_b1),
      .ld_b2(tbl_b2)
   );

   // Pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_meta_q <= 1'b1;
         sel_s_q <= 1'b1;
      end else begin
         sel_meta_q <= nvm_sel_n;
         sel_s_q <= sel_meta_q;
      end
   end

   assign busy = (st_q != ST_IDLE) || store_q;

   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      cnt_d = cnt_q;
      cfg_addr_d = cfg_addr_q;
      cfg_wr_d = 1'b0;
      cfg_wdata_d = cfg_wdata_q;
      apply_d = 1'b0;
      srst_d = 1'b0;
      req_d = req_q;
      we_d = we_q;
      naddr_d = naddr_q;
      nwdata_d = nwdata_q;
      sum_d = sum_q;
      err_d = err_q;
      load_d = load_q;
      wen_d = wen_q;
      reload_d = 1'b0;
      store_d = store_q;
      rdata_d = rdata_q;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
         wen_d = reg_wdata[BIT_WEN];
         reload_d = reg_wdata[BIT_RELOAD];
      end
      // Store request only taken while unlocked and idle
      if (reg_wr && reg_addr == ADDR_STORE && reg_wdata[BIT_STORE]
          && wen_q && !busy) begin
         store_d = 1'b1;
      end
      if (reg_rd) begin
         rdata_d = ZERO8;
         case (reg_addr)
            ADDR_BUSY: rdata_d[BIT_BUSY] = busy;
            ADDR_ERR: rdata_d[BIT_ERR] = err_q;
            ADDR_CTRL: begin
               rdata_d[BIT_WEN] = wen_q;
               rdata_d[BIT_RELOAD] = reload_q;
            end
            ADDR_STORE: rdata_d[BIT_STORE] = store_q;
            default: rdata_d = tbl_hit(reg_addr) ? tbl_host : ZERO8;
         endcase
      end
      case (st_q)
         ST_IDLE: begin
            if (store_q) begin
               load_d = 1'b0;
               st_d = ST_START;
            end else if (reload_q && !sel_s_q) begin
               load_d = 1'b1;
               srst_d = 1'b1;
               st_d = ST_START;
            end
         end
         ST_START: begin
            idx_d = '0;
            sum_d = SUM_SEED;
            err_d = 1'b0;
            naddr_d = '0;
            st_d = ST_SEG;
         end
         ST_SEG: begin
            if (tbl_b0 == OP_END) begin
               st_d = ST_SUM;
            end else if (tbl_b0 == OP_APPLY) begin
               st_d = ST_APPLY;
            end else begin
               cfg_addr_d = {tbl_b1[ADDR_HI_W-1:0], tbl_b2};
               cnt_d = tbl_b0[OP_FLAG_BIT-1:0];
               idx_d = idx_q + STEP_SEG;
               st_d = ST_BYTE;
            end
         end
         ST_APPLY: begin
            apply_d = 1'b1;
            idx_d = idx_q + STEP_OP;
            st_d = ST_SEG;
         end
         ST_BYTE: begin
            req_d = 1'b1;
            we_d = !load_q;
            nwdata_d = cfg_rdata;
            st_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (nvm_ack) begin
               req_d = 1'b0;
               if (load_q) begin
                  cfg_wdata_d = nvm_rdata;
                  cfg_wr_d = 1'b1;
                  sum_d = sum_q ^ nvm_rdata;
               end else begin
                  sum_d = sum_q ^ nwdata_q;
               end
               st_d = ST_NEXT;
            end
         end
         ST_NEXT: begin
            cfg_addr_d = cfg_addr_q + 12'h001;
            naddr_d = naddr_q + NVM_ONE;
            if (cnt_q == '0) begin
               st_d = ST_SEG;
            end else begin
               cnt_d = cnt_q - 7'h01;
               st_d = ST_BYTE;
            end
         end
         // Check byte closes every image so a load can verify it
         ST_SUM: begin
            req_d = 1'b1;
            we_d = !load_q;
            nwdata_d = sum_q;
            st_d = ST_SUM_WAIT;
         end
         ST_SUM_WAIT: begin
            if (nvm_ack) begin
               req_d = 1'b0;
               if (load_q && nvm_rdata != sum_q) begin
                  err_d = 1'b1;
               end
               st_d = ST_DONE;
            end
         end
         ST_DONE: begin
            store_d = 1'b0;
            st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         idx_q <= '0;
         cnt_q <= '0;
         cfg_addr_q <= '0;
         cfg_wr_q <= 1'b0;
         cfg_wdata_q <= '0;
         apply_q <= 1'b0;
         srst_q <= 1'b0;
         req_q <= 1'b0;
         we_q <= 1'b0;
         naddr_q <= '0;
         nwdata_q <= '0;
         sum_q <= SUM_SEED;
         err_q <= 1'b0;
         load_q <= 1'b0;
         wen_q <= 1'b0;
         reload_q <= 1'b0;
         store_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         cnt_q <= cnt_d;
         cfg_addr_q <= cfg_addr_d;
         cfg_wr_q <= cfg_wr_d;
         cfg_wdata_q <= cfg_wdata_d;
         apply_q <= apply_d;
         srst_q <= srst_d;
         req_q <= req_d;
         we_q <= we_d;
         naddr_q <= naddr_d;
         nwdata_q <= nwdata_d;
         sum_q <= sum_d;
         err_q <= err_d;
         load_q <= load_d;
         wen_q <= wen_d;
         reload_q <= reload_d;
         store_q <= store_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign nvm_req = req_q;
   assign nvm_we = we_q;
   assign nvm_addr = naddr_q;
   assign nvm_wdata = nwdata_q;
   assign cfg_addr = cfg_addr_q;
   assign cfg_wr = cfg_wr_q;
   assign cfg_wdata = cfg_wdata_q;
   assign cfg_apply = apply_q;
   assign cfg_soft_rst = srst_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_launch;
      st_q == ST_START ##1 st_q == ST_SEG;
   endsequence
   sequence s_apply;
      cfg_apply ##1 !cfg_apply;
   endsequence

   a_reload_selfclr: assert property (
      reload_q && !(reg_wr && reg_addr == ADDR_CTRL) |=> !reload_q)
      else $error("reload bit did not clear");
   a_store_locked: assert property (
      reg_wr && reg_addr == ADDR_STORE && !wen_q && !store_q
      |=> !store_q)
      else $error("store taken while locked");
   a_busy_read: assert property (
      reg_rd && reg_addr == ADDR_BUSY |=> reg_rdata == {7'h00, $past(busy)})
      else $error("busy read wrong");
   a_err_read: assert property (
      reg_rd && reg_addr == ADDR_ERR |=> reg_rdata == {7'h00, $past(err_q)})
      else $error("error read wrong");
   a_err_set: assert property (
      st_q == ST_SUM_WAIT && nvm_ack && load_q && nvm_rdata != sum_q
      |=> err_q)
      else $error("bad check byte not flagged");
   a_store_run: assert property (
      st_q == ST_IDLE && store_q |=> s_launch)
      else $error("store did not start");
   a_store_done: assert property (st_q == ST_DONE |=> !store_q)
      else $error("store bit not cleared");
   a_reload_go: assert property (
      st_q == ST_IDLE && reload_q && !sel_s_q && !store_q
      |=> cfg_soft_rst && load_q ##1 st_q == ST_SEG)
      else $error("reload did not start");
   a_load_write: assert property (
      st_q == ST_WAIT && nvm_ack && load_q
      |=> cfg_wr && cfg_wdata == $past(nvm_rdata))
      else $error("loaded byte not written");
   a_apply_pulse: assert property (st_q == ST_APPLY |=> s_apply)
      else $error("apply pulse wrong");
   a_end_stop: assert property (
      st_q == ST_SEG && tbl_b0 == OP_END |=> st_q == ST_SUM)
      else $error("walk did not stop at end");
endmodule
`default_nettype wire

// [design/ncl_pkg.sv]
// Constants, table defaults and state type for the config loader
package ncl_pkg;
   // Register map
   localparam logic [11:0] ADDR_TBL_FIRST = 12'hA00;
   localparam logic [11:0] ADDR_TBL_LAST = 12'hA16;
   localparam logic [11:0] ADDR_BUSY = 12'hB00;
   localparam logic [11:0] ADDR_ERR = 12'hB01;
   localparam logic [11:0] ADDR_CTRL = 12'hB02;
   localparam logic [11:0] ADDR_STORE = 12'hB03;
   localparam int TBL_DEPTH = 23;
   localparam int IDX_W = 5;
   // Field positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_ERR = 0;
   localparam int BIT_WEN = 0;
   localparam int BIT_RELOAD = 1;
   localparam int BIT_STORE = 0;
   localparam int OP_FLAG_BIT = 7;
   localparam int ADDR_HI_W = 4;
   // Entry encodings
   localparam logic [7:0] OP_APPLY = 8'h80;
   localparam logic [7:0] OP_END = 8'hFF;
   localparam logic [4:0] STEP_SEG = 5'h03;
   localparam logic [4:0] STEP_OP = 5'h01;
   localparam logic [7:0] SUM_SEED = 8'hA5;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_SEG, ST_BYTE, ST_WAIT, ST_NEXT,
      ST_APPLY, ST_SUM, ST_SUM_WAIT, ST_DONE
   } ncl_state_e;

   // Segment: length-1, address high, address low
   function automatic logic [7:0] tbl_default(input int i);
      case (i)
         0: tbl_default = 8'h1F;
         1: tbl_default = 8'h00;
         2: tbl_default = 8'h00;
         3: tbl_default = 8'h3F;
         4: tbl_default = 8'h00;
         5: tbl_default = 8'hF0;
         6: tbl_default = 8'h2F;
         7: tbl_default = 8'h01;
         8: tbl_default = 8'h90;
         9: tbl_default = 8'h3F;
         10: tbl_default = 8'h01;
         11: tbl_default = 8'hE0;
         12: tbl_default = 8'h12;
         13: tbl_default = 8'h02;
         14: tbl_default = 8'h20;
         15: tbl_default = OP_APPLY;
         default: tbl_default = OP_END;
      endcase
   endfunction
endpackage

// [design/ncl_seg_table.sv]
// Segment table storage with power-on contents
`timescale 1ns/1ps
`default_nettype none
module ncl_seg_table #(
   parameter int DEPTH = ncl_pkg::TBL_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host port
   input wire logic wr_en,
   input wire logic [ncl_pkg::IDX_W-1:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [ncl_pkg::IDX_W-1:0] rd_idx,
   output logic [7:0] rd_data,
   // Loader port, three bytes from ld_idx
   input wire logic [ncl_pkg::IDX_W-1:0] ld_idx,
   output logic [7:0] ld_b0,
   output logic [7:0] ld_b1,
   output logic [7:0] ld_b2
);
   if (DEPTH < 1 || DEPTH > (1 << ncl_pkg::IDX_W) - 3) begin : g_chk
      $error("ncl_seg_table: DEPTH out of range");
   end

   logic [7:0] tbl_q [DEPTH];
   logic [7:0] tbl_d [DEPTH];

   // Reads past the end see the end opcode, so a walk always stops
   function automatic logic [7:0] rd(input logic [ncl_pkg::IDX_W:0] i);
      rd = (int'(i) < DEPTH) ? tbl_q[int'(i)] : ncl_pkg::OP_END;
   endfunction

   always_comb begin
      tbl_d = tbl_q;
      if (wr_en && int'(wr_idx) < DEPTH) begin
         tbl_d[int'(wr_idx)] = wr_data;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            tbl_q[g] <= ncl_pkg::tbl_default(g);
         end else begin
            tbl_q[g] <= tbl_d[g];
         end
      end
   end

   assign rd_data = rd({1'b0, rd_idx});
   assign ld_b0 = rd({1'b0, ld_idx});
   assign ld_b1 = rd({1'b0, ld_idx} + 6'h01);
   assign ld_b2 = rd({1'b0, ld_idx} + 6'h02);
endmodule
`default_nettype wire

// [bench/ncl_mem_model.sv]
// Behavioural nonvolatile memory answering the loader's byte requests
`timescale 1ns/1ps
`default_nettype none
module ncl_mem_model #(
   parameter int AW = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Memory port
   input wire logic nvm_req,
   input wire logic nvm_we,
   input wire logic [AW-1:0] nvm_addr,
   input wire logic [7:0] nvm_wdata,
   output logic nvm_ack,
   output logic [7:0] nvm_rdata,
   // Scenario controls
   input wire logic slow,
   input wire logic corrupt
);
   logic [7:0] mem [0:(1<<AW)-1];
   int wait_q;

   always_ff @(posedge clk) begin
      nvm_ack <= 1'b0;
      // Read data is only good in the ack cycle, so it toggles otherwise
      nvm_rdata <= ~nvm_rdata;
      if (!rst_n) begin
         wait_q <= 0;
         nvm_rdata <= 8'h5A;
      end else if (nvm_req && !nvm_ack) begin
         if (wait_q >= (slow ? 4 : 0)) begin
            nvm_ack <= 1'b1;
            wait_q <= 0;
            if (nvm_we) begin
               mem[nvm_addr] <= nvm_wdata;
            end else begin
               // Only byte 0 is hit: flipping the check byte too cancels
               nvm_rdata <= mem[nvm_addr]
                  ^ {7'h00, corrupt && nvm_addr == '0};
            end
         end else begin
            wait_q <= wait_q + 1;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic nvm_sel_n = 1'b1;
   logic nvm_req, nvm_we, nvm_ack;
   logic [9:0] nvm_addr;
   logic [7:0] nvm_wdata, nvm_rdata, cfg_rdata, cfg_wdata, d;
   logic [11:0] cfg_addr;
   logic cfg_wr, cfg_apply, cfg_soft_rst;
   logic slow = 1'b0;
   logic corrupt = 1'b0;
   logic cfg_chk = 1'b1;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_wr, n_load, n_apply, n_srst, n_bad;
   logic [7:0] tbl [8] = '{8'h00, 8'h00, 8'h05, 8'h80, 8'hFF, 8'h00,
      8'h00, 8'h10};

   always #2 clk = ~clk;

   // Buffer contents depend on address, so misplaced bytes show up
   function automatic logic [7:0] buf_val(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h3};
   endfunction
   assign cfg_rdata = buf_val(cfg_addr);

   ncl_loader #(.NVM_AW(10)) dut (.clk(clk), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nvm_sel_n(nvm_sel_n),
      .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata),
      .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .cfg_apply(cfg_apply),
      .cfg_soft_rst(cfg_soft_rst));

   ncl_mem_model #(.AW(10)) mem_i (.clk(clk), .rst_n(rst_n),
      .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
      .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata),
      .slow(slow), .corrupt(corrupt));

   always @(posedge clk) begin
      if (nvm_req && nvm_ack && nvm_we) n_wr++;
      if (cfg_apply) n_apply++;
      if (cfg_soft_rst) n_srst++;
      if (cfg_wr) begin
         n_load++;
         if (cfg_chk && cfg_wdata !== buf_val(cfg_addr)) n_bad++;
      end
   end

   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic clr;
      n_wr = 0;
      n_load = 0;
      n_apply = 0;
      n_srst = 0;
      n_bad = 0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge clk) #1;
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk) #1;
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      rd(a, d);
      chk(d, e);
   endtask

   // Pin passes a two-stage synchroniser before the loader sees it
   task automatic pin(input logic v);
      @(posedge clk) #1;
      nvm_sel_n = v;
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 3000; i++) begin
         rd(ncl_pkg::ADDR_BUSY, d);
         if (d[0] === 1'b0) return;
      end
      n_mismatch++;
      $display("[ERR] t=%0t busy=%h exp=%h", $time, d, 8'h00);
      end_of_test;
   endtask

   task automatic s_reset;
      rdc(ncl_pkg::ADDR_BUSY, 8'h00);
      rdc(ncl_pkg::ADDR_ERR, 8'h00);
      rdc(ncl_pkg::ADDR_CTRL, 8'h00);
      rdc(ncl_pkg::ADDR_STORE, 8'h00);
      rdc(ncl_pkg::ADDR_TBL_FIRST, 8'h1F);
      rdc(12'hA0F, 8'h80);
      rdc(ncl_pkg::ADDR_TBL_LAST, 8'hFF);
      wr(12'h300, 8'hFF);
      rdc(12'h300, 8'h00);
   endtask

   task automatic s_locked;
      clr;
      wr(ncl_pkg::ADDR_STORE, 8'h01);
      rdc(ncl_pkg::ADDR_STORE, 8'h00);
      repeat (10) @(posedge clk);
      chk(n_wr, 0);
   endtask

   task automatic s_store;
      clr;
      wr(ncl_pkg::ADDR_CTRL, 8'h01);
      wr(ncl_pkg::ADDR_STORE, 8'h01);
      rdc(ncl_pkg::ADDR_STORE, 8'h01);
      rdc(ncl_pkg::ADDR_BUSY, 8'h01);
      wr(ncl_pkg::ADDR_TBL_FIRST, 8'h00);
      wait_idle;
      chk(n_wr, 228);
      chk(n_apply, 1);
      chk(mem_i.mem[0], buf_val(12'h000));
      rdc(ncl_pkg::ADDR_STORE, 8'h00);
      rdc(ncl_pkg::ADDR_ERR, 8'h00);
      rdc(ncl_pkg::ADDR_TBL_FIRST, 8'h1F);
   endtask

   task automatic reload;
      wr(ncl_pkg::ADDR_CTRL, 8'h02);
      repeat (3) @(posedge clk);
      wait_idle;
   endtask

   task automatic s_reload;
      clr;
      pin(1'b0);
      reload;
      chk(n_srst, 1);
      chk(n_load, 227);
      chk(n_bad, 0);
      chk(n_apply, 1);
      rdc(ncl_pkg::ADDR_CTRL, 8'h00);
      rdc(ncl_pkg::ADDR_ERR, 8'h00);
   endtask

   task automatic s_pin_high;
      clr;
      pin(1'b1);
      wr(ncl_pkg::ADDR_CTRL, 8'h02);
      repeat (20) @(posedge clk);
      chk(n_srst, 0);
      chk(n_load, 0);
   endtask

   task automatic s_custom;
      clr;
      slow = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(ncl_pkg::ADDR_TBL_FIRST + 12'(i), tbl[i]);
      end
      rdc(12'hA03, 8'h80);
      wr(ncl_pkg::ADDR_CTRL, 8'h01);
      wr(ncl_pkg::ADDR_STORE, 8'h01);
      repeat (2) @(posedge clk);
      wait_idle;
      chk(n_wr, 2);
      chk(n_apply, 1);
      chk(mem_i.mem[0], buf_val(12'h005));
      chk(mem_i.mem[1], 8'hA3);
      clr;
      pin(1'b0);
      reload;
      chk(n_load, 1);
      chk(n_bad, 0);
   endtask

   task automatic s_error;
      // Corrupted bytes are expected here, so the data monitor rests
      corrupt = 1'b1;
      cfg_chk = 1'b0;
      reload;
      rdc(ncl_pkg::ADDR_ERR, 8'h01);
      corrupt = 1'b0;
      cfg_chk = 1'b1;
      reload;
      rdc(ncl_pkg::ADDR_ERR, 8'h00);
   endtask

   initial begin
      clr;
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      s_reset;
      s_locked;
      s_store;
      s_reload;
      s_pin_high;
      s_custom;
      s_error;
      end_of_test;
   end
endmodule
`default_nettype wire
